// file: bench/serial_node.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Far-side serial node
// ----------------------------------------
module serial_node #(
    parameter int BIT_CYC = 8
) (
    input wire logic aclk,
    input wire logic line_in,
    input wire logic data_in,
    input wire logic sync_mode,
    input wire logic clk_idle,
    output logic rx_line,
    output logic [7:0] frame_byte,
    output logic [4:0] frame_bits,
    output logic frame_stop,
    output logic [7:0] frame_cnt,
    output logic [7:0] sync_byte,
    output logic [7:0] sync_edges
);
    logic [13:0] shreg;
    int nbits;

    initial begin
        rx_line = 1'b1;
        frame_cnt = 8'h00;
        sync_edges = 8'h00;
        sync_byte = 8'h00;
    end

    task automatic drive(input logic v);
        @(posedge aclk);
        rx_line <= v;
    endtask

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge aclk);
            rx_line <= f[i];
            repeat (BIT_CYC - 1) @(posedge aclk);
        end
    endtask

    // A frame whose nine bits after start are all zero is read on as a break.
    always begin
        @(negedge line_in);
        if (!sync_mode) begin
            repeat (BIT_CYC / 2) @(posedge aclk);
            shreg = '0;
            nbits = 1;
            do begin
                repeat (BIT_CYC) @(posedge aclk);
                shreg[nbits] = line_in;
                nbits++;
            end while (nbits < 14 && !(nbits == 10 && shreg[9:1] != 9'h000));
            frame_bits <= 5'(nbits);
            frame_byte <= shreg[8:1];
            frame_stop <= shreg[nbits-1];
            frame_cnt <= frame_cnt + 8'h01;
        end
    end

    // Data is stable at the edge that leaves the idle level.
    always @(line_in) begin
        if (sync_mode && line_in !== clk_idle) begin
            sync_byte <= {data_in, sync_byte[7:1]};
            sync_edges <= sync_edges + 8'h01;
        end
    end
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
    import serial_port_pkg::*;
    localparam int BIT_CYC = 8;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, f0, e0;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp, wrsp;
    logic sync_mode, clk_idle;
    wire logic receive_pin;
    wire logic node_rx;
    serial_out_s pins;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    serial_break_wake dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .receive_pin(receive_pin),
        .pins(pins));

    serial_node #(.BIT_CYC(BIT_CYC)) node (.aclk(aclk), .line_in(pins.tx_pin),
        .data_in(pins.data_out), .sync_mode(sync_mode), .clk_idle(clk_idle),
        .rx_line(node_rx), .frame_byte(), .frame_bits(), .frame_stop(), .frame_cnt(),
        .sync_byte(), .sync_edges());

    // The data line carries whoever drives it; the node yields while the port sends.
    assign receive_pin = pins.data_oe ? pins.data_out : node_rx;

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic report_and_stop();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %0t %s", $time, msg);
            num_errors++;
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awready === 1'b1 && !aw_done) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w_done) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        wrsp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
        input string msg);
        axi_read(a);
        chk(rd & {24'h00_0000, m}, {24'h00_0000, e}, msg);
    endtask

    task automatic wait_frames(input logic [7:0] n);
        while (node.frame_cnt != n) @(posedge aclk);
    endtask

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        sync_mode = 1'b0;
        clk_idle = 1'b1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(pins.tx_pin, 1'b1, "tx idle after reset");
        rchk(OFS_RX_CTRL, 8'hFF, 8'h00, "rx ctrl reset");
        rchk(OFS_TX_CTRL, 8'hFF, 8'h02, "tx ctrl reset");
        axi_read(8'h20);
        chk(rsp, RESP_SLVERR, "unmapped read response");
        chk(rd, 32'h0000_0000, "unmapped read data");
        axi_write(8'h20, 8'h11);
        chk(wrsp, RESP_SLVERR, "unmapped write");
        axi_write(OFS_DIV_LOW, 8'h07);
        rchk(OFS_DIV_LOW, 8'hFF, 8'h07, "divisor readback");
        axi_write(OFS_RX_CTRL, 8'h90);
        rchk(OFS_BAUD_CTRL, 8'h40, 8'h40, "receiver idle");
        axi_write(OFS_BAUD_CTRL, 8'h02);
        node.drive(1'b0);
        repeat (4) @(posedge aclk);
        rchk(OFS_FLAGS, 8'h20, 8'h20, "wake flag");
        rchk(OFS_BAUD_CTRL, 8'h02, 8'h02, "wake held low line");
        repeat (12 * BIT_CYC) @(posedge aclk);
        node.drive(1'b1);
        repeat (8) @(posedge aclk);
        rchk(OFS_BAUD_CTRL, 8'h02, 8'h00, "wake cleared on rise");
        axi_read(OFS_RX_DATA);
        rchk(OFS_FLAGS, 8'h20, 8'h00, "flag cleared by read");
        node.send_byte(8'h3C);
        repeat (20) @(posedge aclk);
        rchk(OFS_FLAGS, 8'h20, 8'h20, "byte after wake flagged");
        rchk(OFS_RX_DATA, 8'hFF, 8'h3C, "byte after wake");
        axi_write(OFS_DIV_LOW, 8'h0A);
        node.drive(1'b0);
        repeat (13 * BIT_CYC - 1) @(posedge aclk);
        node.drive(1'b1);
        repeat (8) @(posedge aclk);
        rchk(OFS_FLAGS, 8'h20, 8'h20, "slow rate break flagged");
        rchk(OFS_RX_DATA, 8'hFF, 8'h00, "slow rate break reads zero");
        axi_write(OFS_DIV_LOW, 8'h07);
        f0 = node.frame_cnt;
        axi_write(OFS_TX_CTRL, 8'h28);
        axi_write(OFS_TX_DATA, 8'hFF);
        rchk(OFS_TX_CTRL, 8'h0A, 8'h08, "busy during break");
        axi_write(OFS_TX_DATA, 8'h55);
        rchk(OFS_FLAGS, 8'h10, 8'h00, "sync held in buffer");
        wait_frames(f0 + 8'h01);
        chk({node.frame_bits, node.frame_stop}, {5'h0E, 1'b1}, "break framing");
        chk(node.frame_byte, 8'h00, "break carries zeros");
        repeat (8) @(posedge aclk);
        rchk(OFS_TX_CTRL, 8'h0A, 8'h00, "break bit cleared");
        rchk(OFS_FLAGS, 8'h10, 8'h10, "buffer handed over");
        wait_frames(f0 + 8'h02);
        chk({node.frame_bits, node.frame_byte}, {5'h0A, 8'h55}, "sync after break");
        repeat (12) @(posedge aclk);
        rchk(OFS_TX_CTRL, 8'h0A, 8'h02, "shifter empty again");
        for (int p = 1; p >= 0; p--) begin
            sync_mode <= 1'b1;
            clk_idle <= p[0];
            axi_write(OFS_BAUD_CTRL, p[0] ? 8'h10 : 8'h00);
            axi_write(OFS_TX_CTRL, 8'hB0);
            repeat (4) @(posedge aclk);
            chk(pins.tx_pin, p[0], "clock idle level");
            e0 = node.sync_edges;
            axi_write(OFS_TX_DATA, 8'hA5);
            repeat (4) @(posedge aclk);
            chk(pins.data_oe, 1'b1, "data line driven");
            repeat (156) @(posedge aclk);
            chk(node.sync_edges - e0, 8'h08, "eight clock pulses");
            chk(node.sync_byte, 8'hA5, "clocked data");
            chk(pins.tx_pin, p[0], "clock back to idle");
            chk(pins.data_oe, 1'b0, "data line released");
        end
        axi_read(OFS_RX_DATA);
        axi_write(OFS_BAUD_CTRL, 8'h02);
        node.drive(1'b0);
        repeat (10) @(posedge aclk);
        rchk(OFS_FLAGS, 8'h20, 8'h00, "no wake in clocked mode");
        node.drive(1'b1);
        repeat (4) @(posedge aclk);
        report_and_stop();
    end
endmodule
`default_nettype wire

// file: design/serial_break_wake.sv
// What this block does
// - Wake enable holds the receiver idle, watching only for a wake event.
// - Wake detection works only in asynchronous mode.
// - A falling receive-line edge is the wake event.
// - A wake event sets the receive-complete flag.
// - Reading the receive data buffer clears the receive-complete flag.
// - A rising edge after the wake event clears wake enable; reception resumes.
// - A break is a start bit, twelve zero bits and a stop bit.
// - Send-break with transmit enable sends a break, ignoring the written data.
// - Hardware clears send-break after the break's stop bit is sent.
// - A byte buffered during the break is sent right after it.
// - Shifter-empty shows break activity like an ordinary character.
// - With wake on, flag on the falling edge, then flag the next byte.
// - In sync mode with port enable, clock-source select places the port in clocked master mode.
// - Clocked mode is half-duplex: receive and transmit exclude each other.
// - Sync mode with port enable makes transmit pin clock, receive pin data.
// - In master mode the device drives the bit clock itself.
// - Clock polarity one idles the clock high, zero idles it low.
// - Moving the buffer into the shifter sets transmit-buffer-empty.
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module serial_break_wake (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic receive_pin,
    output serial_port_pkg::serial_out_s pins
);
    import serial_port_pkg::*;

    state_s r;
    state_s n;
    logic async_mode;
    logic master_mode;
    logic wake_on;
    logic fall;
    logic rise;
    logic rx_set;
    logic rx_clr;
    logic load_async;
    logic [15:0] divisor;

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[7:5] == 3'h0) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [7:0] read_value(input state_s s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            OFS_RX_CTRL: v = s.rx_ctrl;
            OFS_RX_DATA: v = s.rx_data;
            OFS_TX_CTRL: begin
                v = s.tx_ctrl;
                v[BIT_SHIFTER_EMPTY] = (s.eng == ENG_IDLE);
            end
            OFS_BAUD_CTRL: begin
                v = s.baud_ctrl;
                v[BIT_RX_IDLE] = !s.rx_busy;
            end
            OFS_DIV_HIGH: v = s.div_high;
            OFS_DIV_LOW: v = s.div_low;
            OFS_FLAGS: begin
                v[BIT_RX_COMPLETE] = s.rx_flag;
                v[BIT_TX_BUF_EMPTY] = s.tx_ctrl[BIT_TX_ENABLE] && !s.tx_buf_full;
            end
            default: v = 8'h00;
        endcase
        read_value = v;
    endfunction

    assign divisor = {r.div_high, r.div_low};
    assign async_mode = r.rx_ctrl[BIT_PORT_ENABLE] && !r.tx_ctrl[BIT_SYNC_MODE];
    assign master_mode = r.rx_ctrl[BIT_PORT_ENABLE] && r.tx_ctrl[BIT_SYNC_MODE]
        && r.tx_ctrl[BIT_CLOCK_SOURCE];
    assign wake_on = r.baud_ctrl[BIT_WAKE_ENABLE] && async_mode;
    assign fall = r.rx_prev && !r.rx_s2;
    assign rise = !r.rx_prev && r.rx_s2;
    assign load_async = (r.eng == ENG_IDLE) && async_mode && r.tx_ctrl[BIT_TX_ENABLE]
        && r.tx_buf_full;

    always_comb begin
        n = r;
        rx_set = 1'h0;
        rx_clr = 1'h0;
        // Only the second stage and rx_prev are ever looked at, so metastability stays contained.
        n.rx_s1 = receive_pin;
        n.rx_s2 = r.rx_s1;
        n.rx_prev = r.rx_s2;

        // ----------------------------------------
        // AXI4-Lite slave
        // ----------------------------------------
        if (r.awready && awvalid) begin
            n.aw_got = 1'h1;
            n.waddr = awaddr;
        end
        if (r.wready && wvalid) begin
            n.w_got = 1'h1;
            n.wdata = wdata[7:0];
            n.wlane = wstrb[0];
        end
        if (r.bvalid && bready) begin
            n.bvalid = 1'h0;
        end
        if (r.rvalid && rready) begin
            n.rvalid = 1'h0;
        end
        if (r.arready && arvalid) begin
            n.rvalid = 1'h1;
            n.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            n.rdata = {24'h00_0000, read_value(r, araddr)};
            rx_clr = (araddr == OFS_RX_DATA);
        end

        // ----------------------------------------
        // Wake detection and asynchronous receive
        // ----------------------------------------
        if (!wake_on) begin
            n.wake_armed = 1'h0;
        end
        if (wake_on) begin
            n.rx_busy = 1'h0;
            if (fall) begin
                n.wake_armed = 1'h1;
                rx_set = 1'h1;
            end
            if (r.wake_armed && rise) begin
                n.baud_ctrl[BIT_WAKE_ENABLE] = 1'h0;
                n.wake_armed = 1'h0;
            end
        end else if (async_mode && r.rx_ctrl[BIT_CONT_RX]) begin
            if (!r.rx_busy && fall) begin
                n.rx_busy = 1'h1;
                n.rx_cnt = divisor >> 1;
                n.rx_bits = 4'h0;
            end else if (r.rx_busy && r.rx_cnt == 16'h0000) begin
                n.rx_cnt = divisor;
                n.rx_bits = r.rx_bits + 4'h1;
                if (r.rx_bits == 4'h0 && r.rx_s2) begin
                    n.rx_busy = 1'h0;
                end else if (r.rx_bits == RX_STOP_INDEX) begin
                    n.rx_busy = 1'h0;
                    n.rx_data = r.rx_shift;
                    rx_set = 1'h1;
                end else if (r.rx_bits != 4'h0) begin
                    n.rx_shift = {r.rx_s2, r.rx_shift[7:1]};
                end
            end else if (r.rx_busy) begin
                n.rx_cnt = r.rx_cnt - 16'h0001;
            end
        end else begin
            n.rx_busy = 1'h0;
        end

        // ----------------------------------------
        // Transmit and clocked engine
        // ----------------------------------------
        case (r.eng)
            ENG_IDLE: begin
                n.phase = 1'h0;
                n.tx_cnt = divisor;
                if (load_async) begin
                    n.eng = ENG_ASYNC;
                    n.tx_buf_full = 1'h0;
                    n.tx_break = r.tx_ctrl[BIT_SEND_BREAK];
                    if (r.tx_ctrl[BIT_SEND_BREAK]) begin
                        n.tx_shift = BREAK_FRAME;
                        n.tx_bits = {1'h0, BREAK_BITS};
                    end else begin
                        n.tx_shift = {5'h1F, r.tx_buf, 1'h0};
                        n.tx_bits = {1'h0, CHAR_BITS};
                    end
                end else if (master_mode && r.tx_ctrl[BIT_TX_ENABLE] && r.tx_buf_full) begin
                    n.eng = ENG_SYNC_TX;
                    n.tx_buf_full = 1'h0;
                    n.tx_shift = {6'h00, r.tx_buf};
                    n.tx_bits = SYNC_HALF_BITS;
                end else if (master_mode && !r.tx_ctrl[BIT_TX_ENABLE]
                    && (r.rx_ctrl[BIT_CONT_RX] || r.rx_ctrl[BIT_SINGLE_RX])) begin
                    n.eng = ENG_SYNC_RX;
                    n.tx_bits = SYNC_HALF_BITS;
                end
            end
            ENG_ASYNC: begin
                if (r.tx_cnt == 16'h0000) begin
                    n.tx_cnt = divisor;
                    n.tx_shift = {1'h1, r.tx_shift[13:1]};
                    n.tx_bits = r.tx_bits - 5'h01;
                    if (r.tx_bits == 5'h01) begin
                        n.eng = ENG_IDLE;
                        if (r.tx_break) begin
                            n.tx_ctrl[BIT_SEND_BREAK] = 1'h0;
                        end
                    end
                end else begin
                    n.tx_cnt = r.tx_cnt - 16'h0001;
                end
            end
            ENG_SYNC_TX, ENG_SYNC_RX: begin
                if (r.tx_cnt == 16'h0000) begin
                    n.tx_cnt = divisor;
                    n.phase = !r.phase;
                    n.tx_bits = r.tx_bits - 5'h01;
                    // Data moves as the clock returns to idle, so the far end sees it stable.
                    if (r.phase) begin
                        n.tx_shift = {r.rx_s2, r.tx_shift[13:1]};
                    end
                    if (r.tx_bits == 5'h01) begin
                        n.eng = ENG_IDLE;
                        if (r.eng == ENG_SYNC_RX) begin
                            n.rx_data = n.tx_shift[13:6];
                            n.rx_ctrl[BIT_SINGLE_RX] = 1'h0;
                            rx_set = 1'h1;
                        end
                    end
                end else begin
                    n.tx_cnt = r.tx_cnt - 16'h0001;
                end
            end
            default: n.eng = ENG_IDLE;
        endcase

        // ----------------------------------------
        // Register writes; hardware set beats software clear
        // ----------------------------------------
        if (r.aw_got && r.w_got && !r.bvalid) begin
            n.aw_got = 1'h0;
            n.w_got = 1'h0;
            n.bvalid = 1'h1;
            n.bresp = mapped(r.waddr) ? RESP_OKAY : RESP_SLVERR;
            if (r.wlane) begin
                case (r.waddr)
                    OFS_RX_CTRL: n.rx_ctrl = (n.rx_ctrl & ~MASK_RX_CTRL)
                        | (r.wdata & MASK_RX_CTRL);
                    OFS_TX_CTRL: n.tx_ctrl = (n.tx_ctrl & ~MASK_TX_CTRL)
                        | (r.wdata & MASK_TX_CTRL);
                    OFS_TX_DATA: begin
                        n.tx_buf = r.wdata;
                        n.tx_buf_full = 1'h1;
                    end
                    OFS_BAUD_CTRL: n.baud_ctrl = (n.baud_ctrl & ~MASK_BAUD_CTRL)
                        | (r.wdata & MASK_BAUD_CTRL);
                    OFS_DIV_HIGH: n.div_high = r.wdata;
                    OFS_DIV_LOW: n.div_low = r.wdata;
                    default: n.tx_buf = n.tx_buf;
                endcase
            end
        end
        n.rx_flag = rx_set || (r.rx_flag && !rx_clr);
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;
        n.arready = !n.rvalid;

        // ----------------------------------------
        // Pin drive
        // ----------------------------------------
        // clock line idle level
        if (n.tx_ctrl[BIT_SYNC_MODE] && n.rx_ctrl[BIT_PORT_ENABLE]) begin
            n.pins.tx_pin = n.baud_ctrl[BIT_CLOCK_POLARITY]
                ^ (n.phase && n.eng != ENG_IDLE);
            n.pins.data_oe = (n.eng == ENG_SYNC_TX);
            n.pins.data_out = n.tx_shift[0];
        end else begin
            n.pins.tx_pin = (n.eng == ENG_ASYNC) ? n.tx_shift[0] : 1'h1;
            n.pins.data_oe = 1'h0;
            n.pins.data_out = 1'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.rx_s1 <= 1'h1;
            r.rx_s2 <= 1'h1;
            r.rx_prev <= 1'h1;
            r.pins.tx_pin <= 1'h1;
            r.rx_ctrl <= RESET_CTRL;
            r.tx_ctrl <= RESET_CTRL;
            r.baud_ctrl <= RESET_CTRL;
            r.div_high <= RESET_DIV;
            r.div_low <= RESET_DIV;
        end else begin
            r <= n;
        end
    end

    assign awready = r.awready;
    assign wready = r.wready;
    assign bvalid = r.bvalid;
    assign bresp = r.bresp;
    assign arready = r.arready;
    assign rvalid = r.rvalid;
    assign rdata = r.rdata;
    assign rresp = r.rresp;
    assign pins = r.pins;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_wake_idle;
        wake_on && !r.rx_busy |=> !r.rx_busy;
    endproperty
    a_wake_idle: assert property (p_wake_idle) else $error("receiver left idle under wake");

    property p_wake_flag;
        wake_on && fall |=> r.rx_flag;
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("wake edge did not flag");

    property p_read_clear;
        rx_clr && !rx_set |=> !r.rx_flag;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("data read left flag set");

    property p_wake_end;
        wake_on && r.wake_armed && rise |=> !r.baud_ctrl[BIT_WAKE_ENABLE];
    endproperty
    a_wake_end: assert property (p_wake_end) else $error("wake enable not cleared");

    property p_break_frame;
        load_async && r.tx_ctrl[BIT_SEND_BREAK] |=> r.tx_shift == BREAK_FRAME
            && r.tx_bits == 5'h0E ##1 !r.pins.tx_pin;
    endproperty
    a_break_frame: assert property (p_break_frame) else $error("break frame wrong");

    property p_break_clear;
        r.eng == ENG_ASYNC && r.tx_break && r.tx_cnt == 16'h0000 && r.tx_bits == 5'h01
            |=> !r.tx_ctrl[BIT_SEND_BREAK] && r.eng == ENG_IDLE;
    endproperty
    a_break_clear: assert property (p_break_clear) else $error("send break stuck");

    property p_busy_shows;
        r.eng != ENG_IDLE
            |-> (read_value(r, OFS_TX_CTRL) & (8'h01 << BIT_SHIFTER_EMPTY)) == 8'h00;
    endproperty
    a_busy_shows: assert property (p_busy_shows) else $error("shifter empty while busy");

    property p_half_duplex;
        r.eng == ENG_SYNC_TX |-> !r.rx_busy && !$past(rx_set);
    endproperty
    a_half_duplex: assert property (p_half_duplex) else $error("receive during send");

    property p_clock_idle;
        r.eng == ENG_IDLE && master_mode ##1 r.eng == ENG_IDLE && master_mode
            |-> r.pins.tx_pin == r.baud_ctrl[BIT_CLOCK_POLARITY];
    endproperty
    a_clock_idle: assert property (p_clock_idle) else $error("clock idle level wrong");

    property p_buf_empty;
        load_async && !(r.aw_got && r.w_got && !r.bvalid) |=> !r.tx_buf_full;
    endproperty
    a_buf_empty: assert property (p_buf_empty) else $error("buffer not emptied");

endmodule

`default_nettype wire

// file: design/serial_port_pkg.sv
package serial_port_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_RX_CTRL = 8'h00;
    localparam logic [7:0] OFS_RX_DATA = 8'h04;
    localparam logic [7:0] OFS_TX_CTRL = 8'h08;
    localparam logic [7:0] OFS_TX_DATA = 8'h0C;
    localparam logic [7:0] OFS_BAUD_CTRL = 8'h10;
    localparam logic [7:0] OFS_DIV_HIGH = 8'h14;
    localparam logic [7:0] OFS_DIV_LOW = 8'h18;
    localparam logic [7:0] OFS_FLAGS = 8'h1C;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_PORT_ENABLE = 7;
    localparam int BIT_SINGLE_RX = 5;
    localparam int BIT_CONT_RX = 4;
    localparam int BIT_CLOCK_SOURCE = 7;
    localparam int BIT_TX_ENABLE = 5;
    localparam int BIT_SYNC_MODE = 4;
    localparam int BIT_SEND_BREAK = 3;
    localparam int BIT_SHIFTER_EMPTY = 1;
    localparam int BIT_RX_IDLE = 6;
    localparam int BIT_CLOCK_POLARITY = 4;
    localparam int BIT_WAKE_ENABLE = 1;
    localparam int BIT_RX_COMPLETE = 5;
    localparam int BIT_TX_BUF_EMPTY = 4;

    // ----------------------------------------
    // Writable masks, reset values, frames
    // ----------------------------------------
    localparam logic [7:0] MASK_RX_CTRL = 8'hB0;
    localparam logic [7:0] MASK_TX_CTRL = 8'hB8;
    localparam logic [7:0] MASK_BAUD_CTRL = 8'h13;
    localparam logic [7:0] RESET_CTRL = 8'h00;
    localparam logic [7:0] RESET_DIV = 8'h00;
    localparam logic [13:0] BREAK_FRAME = 14'h2000;
    localparam logic [3:0] BREAK_BITS = 4'hE;
    localparam logic [3:0] CHAR_BITS = 4'hA;
    localparam logic [4:0] SYNC_HALF_BITS = 5'h10;
    localparam logic [3:0] RX_STOP_INDEX = 4'h9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_ASYNC = 2'b01,
        ENG_SYNC_TX = 2'b10,
        ENG_SYNC_RX = 2'b11
    } engine_e;

    typedef struct packed {
        logic tx_pin;
        logic data_out;
        logic data_oe;
    } serial_out_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [7:0] wdata;
        logic wlane;
        logic [7:0] rx_ctrl;
        logic [7:0] tx_ctrl;
        logic [7:0] baud_ctrl;
        logic [7:0] div_high;
        logic [7:0] div_low;
        logic [7:0] tx_buf;
        logic tx_buf_full;
        logic [7:0] rx_data;
        logic rx_flag;
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        logic wake_armed;
        logic rx_busy;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bits;
        logic [7:0] rx_shift;
        engine_e eng;
        logic [13:0] tx_shift;
        logic [4:0] tx_bits;
        logic [15:0] tx_cnt;
        logic tx_break;
        logic phase;
        serial_out_s pins;
    } state_s;

endpackage
